// file: logic/blmi_top.v
// Top of the byte-lane mask and inversion codec for a two-lane data channel.
// Assumes the link strobe, data lines and pins come from outside MCLK's domain,
// that commands and mode bits come from same-clock logic, and that the strobe
// is slow enough for MCLK to see every one of its edges.
`timescale 1ns/10ps
`include "blmi_defs.vh"
module blmi_top #(
   parameter BURST_LEN = `BLMI_BURST_LEN,
   parameter IDX_W = `BLMI_BEAT_IDX_W,
   parameter MODE_READ_INV = 1
) (
   input wire MCLK,
   input wire RST_N,
   input wire [7:0] MODE_REGISTER_THREE,
   input wire [7:0] MODE_REGISTER_THIRTEEN,
   input wire CMD_VALID,
   input wire [2:0] CMD_CODE,
   output wire CMD_READY,
   output reg ILLEGAL_CMD,
   input wire LINK_STROBE,
   input wire [15:0] DQ_I,
   output reg [15:0] DQ_O,
   output reg [15:0] DQ_OE,
   input wire [1:0] MASK_INVERT_PIN_I,
   output reg [1:0] MASK_INVERT_PIN_O,
   output reg [1:0] MASK_INVERT_PIN_OE,
   output reg [1:0] PIN_RX_ON,
   output wire WR_VALID,
   input wire WR_READY,
   output wire [15:0] WR_DATA,
   output wire [1:0] WR_BYTE_EN,
   output wire WR_IN_READY,
   output reg WR_OVERRUN,
   input wire RD_VALID,
   output wire RD_READY,
   input wire [15:0] RD_DATA,
   output reg RD_UNDERRUN
);
   localparam S_IDLE = 2'h0;
   localparam S_WRITE = 2'h1;
   localparam S_READ = 2'h2;
   localparam integer LAST_BEAT_INT = BURST_LEN - 1;
   localparam [IDX_W-1:0] LAST_BEAT = LAST_BEAT_INT[IDX_W-1:0];

   reg [1:0] state;
   reg [2:0] cmd;
   reg [IDX_W-1:0] beat;
   reg wr_inv_en;
   reg rd_inv_en;
   reg mask_en;
   reg rx_on;
   reg next_rx_on;
   reg [1:0] next_state;

   // Read drive controls
   reg drv_pins_rd;
   reg [1:0] rd_pin_val;
   reg [15:0] rd_val;
   reg rd_tail;

   // Two flops on everything from the link before any logic looks at it
   reg strobe_s1;
   reg strobe_s2;
   reg strobe_s3;
   reg [15:0] dq_s1;
   reg [15:0] dq_s2;
   reg [1:0] pin_s1;
   reg [1:0] pin_s2;

   // Training store: one word per beat, data and both pin bits
   // No reset, since it is only read back after a training write has filled it
   reg [17:0] train_mem [0:BURST_LEN-1];

   // Both strobe edges are beats; the third flop only marks where the second changed
   wire link_edge = strobe_s2 ^ strobe_s3;
   wire beat_now = link_edge && (state != S_IDLE);
   wire last_now = beat_now && (beat == LAST_BEAT);

   wire mr_wr_inv = MODE_REGISTER_THREE[`BLMI_MR3_WR_INV_BIT];
   wire mr_rd_inv = MODE_REGISTER_THREE[`BLMI_MR3_RD_INV_BIT];
   wire mr_mask = !MODE_REGISTER_THIRTEEN[`BLMI_MODE_REGISTER_THIRTEEN_MASK_OFF_BIT];
   wire mr_any = mr_wr_inv | mr_rd_inv | mr_mask;

   wire is_write = (CMD_CODE == `BLMI_CMD_WRITE);
   wire is_masked = (CMD_CODE == `BLMI_CMD_MASKED_WRITE);
   wire is_read = (CMD_CODE == `BLMI_CMD_READ);
   wire is_mode_read = (CMD_CODE == `BLMI_CMD_MODE_READ);
   wire is_train_wr = (CMD_CODE == `BLMI_CMD_TRAIN_WRITE);
   wire is_train_rd = (CMD_CODE == `BLMI_CMD_TRAIN_READ);
   wire cmd_take = CMD_VALID && (state == S_IDLE);

   assign CMD_READY = (state == S_IDLE);

   wire cur_masked = (cmd == `BLMI_CMD_MASKED_WRITE);
   wire cur_train_wr = (cmd == `BLMI_CMD_TRAIN_WRITE);
   wire cur_train_rd = (cmd == `BLMI_CMD_TRAIN_READ);

   always @* begin
      next_rx_on = 1'b0;
      if (is_write | is_masked) begin
         next_rx_on = mr_mask | mr_wr_inv;
      end else if (is_train_wr) begin
         next_rx_on = mr_any;
      end
   end

   // Unknown codes are taken and simply leave the block idle
   always @* begin
      next_state = S_IDLE;
      case (CMD_CODE)
         `BLMI_CMD_WRITE, `BLMI_CMD_MASKED_WRITE, `BLMI_CMD_TRAIN_WRITE: begin
            next_state = S_WRITE;
         end
         `BLMI_CMD_READ, `BLMI_CMD_MODE_READ, `BLMI_CMD_TRAIN_READ: begin
            next_state = S_READ;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   wire [1:0] pin_bits = rx_on ? pin_s2 : 2'h0;

   wire [17:0] train_word = train_mem[beat];
   wire [15:0] rd_src = cur_train_rd ? train_word[15:0] : RD_DATA;

   wire [15:0] wr_dec;
   wire [1:0] wr_keep;
   wire [15:0] rd_enc;
   wire [1:0] rd_pins;

   genvar g;
   generate
      for (g = 0; g < `BLMI_LANES; g = g + 1) begin : lane
         blmi_lane u_lane (
            .wr_inv_en(wr_inv_en),
            .mask_en(mask_en),
            .masked_cmd(cur_masked),
            .train_cmd(cur_train_wr),
            .wr_byte(dq_s2[g*8+7:g*8]),
            .wr_pin(pin_bits[g]),
            .rd_inv_en(rd_inv_en),
            .rd_byte(rd_src[g*8+7:g*8]),
            .wr_out(wr_dec[g*8+7:g*8]),
            .wr_keep(wr_keep[g]),
            .rd_out(rd_enc[g*8+7:g*8]),
            .rd_pin(rd_pins[g])
         );
      end
   endgenerate

   // Array side takes only beats that keep at least one byte
   wire wr_push = beat_now && (state == S_WRITE) && !cur_train_wr && (wr_keep != 2'h0);
   wire read_beat = beat_now && (state == S_READ);
   assign RD_READY = read_beat && !cur_train_rd;

   // A word that meets a full buffer is lost and flagged on the overrun output
   blmi_buf #(
      .WIDTH(18)
   ) u_buf (
      .clk(MCLK),
      .rst_n(RST_N),
      .in_valid(wr_push),
      .in_ready(WR_IN_READY),
      .in_data({wr_keep, wr_dec}),
      .out_valid(WR_VALID),
      .out_ready(WR_READY),
      .out_data({WR_BYTE_EN, WR_DATA})
   );

   always @(posedge MCLK) begin
      if (!RST_N) begin
         strobe_s1 <= 1'b0;
         strobe_s2 <= 1'b0;
         strobe_s3 <= 1'b0;
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
         pin_s1 <= 2'h0;
         pin_s2 <= 2'h0;
      end else begin
         strobe_s1 <= LINK_STROBE;
         strobe_s2 <= strobe_s1;
         strobe_s3 <= strobe_s2;
         dq_s1 <= DQ_I;
         dq_s2 <= dq_s1;
         pin_s1 <= MASK_INVERT_PIN_I;
         pin_s2 <= pin_s1;
      end
   end

   // Mode bits are frozen per burst so a mid-burst change cannot split a burst
   always @(posedge MCLK) begin
      if (!RST_N) begin
         state <= S_IDLE;
         cmd <= 3'h0;
         beat <= {IDX_W{1'b0}};
         wr_inv_en <= 1'b0;
         rd_inv_en <= 1'b0;
         mask_en <= 1'b0;
         rx_on <= 1'b0;
         ILLEGAL_CMD <= 1'b0;
      end else begin
         ILLEGAL_CMD <= 1'b0;
         case (state)
            S_IDLE: begin
               beat <= {IDX_W{1'b0}};
               if (cmd_take) begin
                  cmd <= CMD_CODE;
                  wr_inv_en <= mr_wr_inv;
                  rd_inv_en <= mr_rd_inv;
                  mask_en <= mr_mask;
                  rx_on <= next_rx_on;
                  ILLEGAL_CMD <= is_masked && !mr_mask;
                  state <= next_state;
               end
            end
            S_WRITE, S_READ: begin
               if (beat_now) begin
                  beat <= beat + {{(IDX_W-1){1'b0}}, 1'b1};
               end
               if (last_now) begin
                  state <= S_IDLE;
                  rx_on <= 1'b0;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   always @(posedge MCLK) begin
      if (beat_now && (state == S_WRITE) && cur_train_wr) begin
         train_mem[beat] <= {pin_bits, dq_s2};
      end
   end

   // Mode read sends raw data with the pin low when the option is off
   wire mode_read_raw = (cmd == `BLMI_CMD_MODE_READ) && (MODE_READ_INV == 0);

   always @* begin
      drv_pins_rd = 1'b0;
      if (is_read | is_mode_read) begin
         drv_pins_rd = mr_rd_inv;
      end else if (is_train_rd) begin
         drv_pins_rd = mr_any;
      end
   end

   always @* begin
      rd_pin_val = rd_pins;
      rd_val = rd_enc;
      if (cur_train_rd) begin
         rd_val = train_word[15:0];
         rd_pin_val = (mask_en | wr_inv_en | rd_inv_en) ? train_word[17:16] : 2'h0;
      end else if (mode_read_raw) begin
         rd_val = RD_DATA;
         rd_pin_val = 2'h0;
      end
   end

   always @(posedge MCLK) begin
      if (!RST_N) begin
         DQ_O <= 16'h0000;
         DQ_OE <= 16'h0000;
         MASK_INVERT_PIN_O <= 2'h0;
         MASK_INVERT_PIN_OE <= 2'h0;
         PIN_RX_ON <= 2'h0;
         WR_OVERRUN <= 1'b0;
         RD_UNDERRUN <= 1'b0;
         rd_tail <= 1'b0;
      end else begin
         WR_OVERRUN <= wr_push && !WR_IN_READY;
         RD_UNDERRUN <= RD_READY && !RD_VALID;
         // Drivers stay on one cycle past the last beat, so that beat goes out driven
         rd_tail <= last_now && (state == S_READ);
         PIN_RX_ON <= {2{rx_on}};
         if (cmd_take && (is_read | is_mode_read | is_train_rd)) begin
            DQ_OE <= 16'hFFFF;
            MASK_INVERT_PIN_OE <= {2{drv_pins_rd}};
         end else if (rd_tail) begin
            DQ_OE <= 16'h0000;
            MASK_INVERT_PIN_OE <= 2'h0;
         end
         if (read_beat) begin
            DQ_O <= rd_val;
            MASK_INVERT_PIN_O <= MASK_INVERT_PIN_OE & rd_pin_val;
         end else if (state == S_IDLE) begin
            DQ_O <= 16'h0000;
            MASK_INVERT_PIN_O <= 2'h0;
         end
      end
   end
endmodule // blmi_top

// file: logic/blmi_defs.vh
// Shared constants of the byte-lane mask and inversion codec.
// Assumes inclusion by bare name from the top and lane design files of the block.
//
// Contract
// - Write inversion follows mode three bit seven
// - Read inversion follows mode three bit six
// - Mask function follows mode thirteen bit five
// - Mask enabled when that bit is zero
// - One pin per byte, whole-byte granularity
// - Pin sampled/driven with the byte's data
// - No mask, no write inversion: receivers off (write training still turns them on when read inversion is on)
// - Read inversion off: pin drivers stay off (read training still drives them when mask or write inversion is on)
// - Plain write: pin high inverts byte
// - Read: more than four ones inverts
// - Masked write, pin high masks byte
// - Both on: pin low, five ones masks
// - Write training: pin is pattern, untouched data
// - Read training: return captured pin pattern
// - Mode read inverts or holds pin low
`ifndef BLMI_DEFS_VH
`define BLMI_DEFS_VH

`define BLMI_CMD_WRITE 3'h1
`define BLMI_CMD_MASKED_WRITE 3'h2
`define BLMI_CMD_READ 3'h3
`define BLMI_CMD_MODE_READ 3'h4
`define BLMI_CMD_TRAIN_WRITE 3'h5
`define BLMI_CMD_TRAIN_READ 3'h6

`define BLMI_MR3_WR_INV_BIT 7
`define BLMI_MR3_RD_INV_BIT 6
`define BLMI_MODE_REGISTER_THIRTEEN_MASK_OFF_BIT 5

`define BLMI_RD_INV_LIMIT 4'h4
`define BLMI_MASK_LIMIT 4'h5
`define BLMI_MASK_LOW_BIT 2

`define BLMI_BURST_LEN 16
`define BLMI_BEAT_IDX_W 4
`define BLMI_LANES 2

`endif

// file: logic/blmi_lane.v
// One byte lane of the codec: write decode and read encode, purely combinational.
// Assumes the caller registers the results and qualifies them with a beat strobe.
`timescale 1ns/10ps
`include "blmi_defs.vh"
module blmi_lane (
   input wire wr_inv_en,
   input wire mask_en,
   input wire masked_cmd,
   input wire train_cmd,
   input wire [7:0] wr_byte,
   input wire wr_pin,
   input wire rd_inv_en,
   input wire [7:0] rd_byte,
   output reg [7:0] wr_out,
   output reg wr_keep,
   output reg [7:0] rd_out,
   output reg rd_pin
);
   function [3:0] ones;
      input [7:0] v;
      integer i;
      begin
         ones = 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            ones = ones + {3'h0, v[i]};
         end
      end
   endfunction

   wire [7:0] high_bits = {wr_byte[7:`BLMI_MASK_LOW_BIT], 2'h0};

   always @* begin
      wr_out = wr_byte;
      wr_keep = 1'b1;
      if (train_cmd) begin
         wr_out = wr_byte;
      end else if (masked_cmd) begin
         if (!mask_en) begin
            wr_keep = 1'b0;
         end else if (!wr_inv_en) begin
            wr_keep = !wr_pin;
         end else begin
            wr_keep = !(!wr_pin && ones(high_bits) >= `BLMI_MASK_LIMIT);
            wr_out = wr_pin ? ~wr_byte : wr_byte;
         end
      end else if (wr_inv_en) begin
         wr_out = wr_pin ? ~wr_byte : wr_byte;
      end
   end

   always @* begin
      rd_pin = rd_inv_en && (ones(rd_byte) > `BLMI_RD_INV_LIMIT);
      rd_out = rd_pin ? ~rd_byte : rd_byte;
   end
endmodule // blmi_lane

// file: logic/blmi_buf.v
// Two-entry valid/ready buffer for decoded write words.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/10ps
module blmi_buf #(
   parameter WIDTH = 18
) (
   input wire clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] slot0;
   reg [WIDTH-1:0] slot1;
   reg [1:0] fill;

   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data = slot0;

   always @(posedge clk) begin
      if (!rst_n) begin
         slot0 <= {WIDTH{1'b0}};
         slot1 <= {WIDTH{1'b0}};
         fill <= 2'h0;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (fill == 2'h0) begin
                  slot0 <= in_data;
               end else begin
                  slot1 <= in_data;
               end
               fill <= fill + 2'h1;
            end
            2'b01: begin
               slot0 <= slot1;
               fill <= fill - 2'h1;
            end
            2'b11: begin
               // Full never pops and pushes together since in_ready is low then
               if (fill == 2'h1) begin
                  slot0 <= in_data;
               end else begin
                  slot0 <= slot1;
                  slot1 <= in_data;
               end
            end
            default: begin
               fill <= fill;
            end
         endcase
      end
   end
endmodule // blmi_buf

// file: tb/blmi_chk_asserts.sv
// Port-level checks of the byte-lane mask and inversion codec.
// Assumes it is bound to blmi_top and sees only that module's ports.
`timescale 1ns/10ps
module blmi_chk #(
   parameter MODE_READ_INV = 1
) (
   input wire MCLK,
   input wire RST_N,
   input wire [7:0] MODE_REGISTER_THREE,
   input wire [7:0] MODE_REGISTER_THIRTEEN,
   input wire CMD_VALID,
   input wire [2:0] CMD_CODE,
   input wire CMD_READY,
   input wire ILLEGAL_CMD,
   input wire [15:0] DQ_O,
   input wire [15:0] DQ_OE,
   input wire [1:0] MASK_INVERT_PIN_O,
   input wire [1:0] MASK_INVERT_PIN_OE,
   input wire [1:0] PIN_RX_ON,
   input wire WR_VALID,
   input wire WR_READY,
   input wire [15:0] WR_DATA,
   input wire [1:0] WR_BYTE_EN,
   input wire RD_READY,
   input wire [15:0] RD_DATA
);
   wire take = CMD_VALID && CMD_READY;
   reg inv_burst;
   function automatic [8:0] enc(input [7:0] b);
      enc = ($countones(b) > 4) ? {1'b1, ~b} : {1'b0, b};
   endfunction
   // Mode bits are frozen per burst, so the inversion choice is latched at the take
   always @(posedge MCLK) begin
      if (!RST_N)
         inv_burst <= 1'b0;
      else if (take)
         inv_burst <= MODE_REGISTER_THREE[6] && (CMD_CODE == 3'h3 || (CMD_CODE == 3'h4 && MODE_READ_INV != 0));
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   chk_busy_take: assert property (take && CMD_CODE != 3'h0 && CMD_CODE != 3'h7 |=> !CMD_READY)
      else $error("ready stayed high after a take");
   chk_illegal_flag: assert property (take && CMD_CODE == 3'h2 && MODE_REGISTER_THIRTEEN[5] |=> ILLEGAL_CMD)
      else $error("masked write with mask off not flagged");
   chk_illegal_cause: assert property (ILLEGAL_CMD |-> $past(take && CMD_CODE == 3'h2 && MODE_REGISTER_THIRTEEN[5]))
      else $error("illegal flag without cause");
   chk_read_encode: assert property (RD_READY && inv_burst |=>
      {MASK_INVERT_PIN_O[1], DQ_O[15:8], MASK_INVERT_PIN_O[0], DQ_O[7:0]} == {enc($past(RD_DATA[15:8])), enc($past(RD_DATA[7:0]))})
      else $error("read inversion wrong");
   chk_read_raw: assert property (RD_READY && !inv_burst |=> DQ_O == $past(RD_DATA))
      else $error("read data altered without inversion");
   chk_drivers_off: assert property (take && (CMD_CODE == 3'h3 || CMD_CODE == 3'h4) && !MODE_REGISTER_THREE[6]
      |=> (MASK_INVERT_PIN_OE == 2'b00) [*8])
      else $error("pin driven with read inversion off");
   chk_drivers_on: assert property (take && CMD_CODE == 3'h3 && MODE_REGISTER_THREE[6]
      |=> MASK_INVERT_PIN_OE == 2'b11 && DQ_OE == 16'hFFFF)
      else $error("read drivers not enabled");
   chk_receivers_off: assert property (take && (CMD_CODE == 3'h1 || CMD_CODE == 3'h2) && MODE_REGISTER_THIRTEEN[5]
      && !MODE_REGISTER_THREE[7] |=> (PIN_RX_ON == 2'b00) [*6])
      else $error("pin receivers on with both functions off");
   chk_buffer_hold: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_DATA) && $stable(WR_BYTE_EN))
      else $error("stalled write word changed");
endmodule // blmi_chk
bind blmi_top blmi_chk #(.MODE_READ_INV(MODE_READ_INV)) u_chk (.MCLK(MCLK), .RST_N(RST_N),
   .MODE_REGISTER_THREE(MODE_REGISTER_THREE), .MODE_REGISTER_THIRTEEN(MODE_REGISTER_THIRTEEN),
   .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_READY(CMD_READY), .ILLEGAL_CMD(ILLEGAL_CMD),
   .DQ_O(DQ_O), .DQ_OE(DQ_OE), .MASK_INVERT_PIN_O(MASK_INVERT_PIN_O), .MASK_INVERT_PIN_OE(MASK_INVERT_PIN_OE),
   .PIN_RX_ON(PIN_RX_ON), .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_DATA(WR_DATA),
   .WR_BYTE_EN(WR_BYTE_EN), .RD_READY(RD_READY), .RD_DATA(RD_DATA));

// file: tb/blmi_ctrl_model.sv
// Memory-controller model: makes the link strobe, drives data and pins on writes
// and captures what the device returns. Assumes the bench fills tx_* first.
`timescale 1ns/10ps
module blmi_ctrl_model (
   output logic link_strobe,
   output wire [15:0] dq_i,
   output wire [1:0] pin_i,
   input wire [15:0] dq_o,
   input wire [15:0] dq_oe,
   input wire [1:0] pin_o,
   input wire [1:0] pin_oe
);
   logic drive = 1'b0;
   logic [15:0] line_dq = 16'h0000;
   logic [1:0] line_pin = 2'b00;
   logic [15:0] tx_dq [0:15];
   logic [1:0] tx_pin [0:15];
   logic [15:0] rx_dq [0:15];
   logic [1:0] rx_pin [0:15];
   logic [1:0] rx_oe [0:15];
   // Enabled driver owns the wire; a released line shows the inverse of its last value
   assign dq_i = (dq_oe & dq_o) | (~dq_oe & line_dq);
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & line_pin);
   initial link_strobe = 1'b0;
   task automatic cap(input integer i);
      rx_dq[i] = dq_o;
      rx_pin[i] = pin_o;
      rx_oe[i] = pin_oe;
   endtask
   task automatic burst();
      integer k;
      #1.3;
      for (k = 0; k < 16; k = k + 1) begin
         if (drive) begin
            line_dq = tx_dq[k];
            line_pin = tx_pin[k];
         end
         #8;
         link_strobe = ~link_strobe;
         #2;
         if (k > 0)
            cap(k - 1);
         #6;
      end
      // The last beat stands for one device cycle only before the drivers let go
      #4;
      cap(15);
      #6;
      line_dq = ~line_dq;
      line_pin = ~line_pin;
   endtask
endmodule // blmi_ctrl_model

// file: tb/tb_byte_lane_mask_inversion.sv
// Self-checking bench of the byte-lane mask and inversion codec.
// Assumes blmi_top, the controller model and the bound checker are compiled.
`timescale 1ns/10ps
module tb_byte_lane_mask_inversion;
   logic mclk, rst_n, cmd_valid, wr_ready, rd_valid, hold;
   logic [7:0] mr3, mode_register_thirteen;
   logic [2:0] cmd_code;
   logic [3:0] rd_idx;
   wire link_strobe;
   wire [15:0] dq_i, dq_o, dq_oe, wr_data;
   wire [1:0] pin_i, pin_o, pin_oe, wr_byte_en;
   wire cmd_ready, illegal_cmd, wr_valid, wr_in_ready, wr_overrun, rd_ready, rd_underrun;
   wire [15:0] rd_data = rd_pat(rd_idx);
   logic [17:0] got[$], exp[$];
   integer num_errors = 0, total_checks = 0, n_ovr = 0, n_ill = 0, n_rd = 0, n_und = 0, i;
   blmi_top #(.BURST_LEN(16), .IDX_W(4), .MODE_READ_INV(1)) uut (.MCLK(mclk), .RST_N(rst_n),
      .MODE_REGISTER_THREE(mr3), .MODE_REGISTER_THIRTEEN(mode_register_thirteen), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
      .CMD_READY(cmd_ready), .ILLEGAL_CMD(illegal_cmd), .LINK_STROBE(link_strobe), .DQ_I(dq_i), .DQ_O(dq_o),
      .DQ_OE(dq_oe), .MASK_INVERT_PIN_I(pin_i), .MASK_INVERT_PIN_O(pin_o), .MASK_INVERT_PIN_OE(pin_oe),
      .PIN_RX_ON(), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .WR_BYTE_EN(wr_byte_en),
      .WR_IN_READY(wr_in_ready), .WR_OVERRUN(wr_overrun), .RD_VALID(rd_valid), .RD_READY(rd_ready),
      .RD_DATA(rd_data), .RD_UNDERRUN(rd_underrun));
   blmi_ctrl_model ctrl (.link_strobe(link_strobe), .dq_i(dq_i), .pin_i(pin_i), .dq_o(dq_o), .dq_oe(dq_oe),
      .pin_o(pin_o), .pin_oe(pin_oe));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   function automatic [15:0] rd_pat(input [3:0] k);
      rd_pat = {~(8'hFF >> k[2:0]), 8'hFF >> k[2:0]};
   endfunction
   function automatic [8:0] enc(input [7:0] b);
      enc = ($countones(b) > 4) ? {1'b1, ~b} : {1'b0, b};
   endfunction
   function automatic [8:0] dec(input [2:0] c, input bit wi, input [7:0] b, input bit p);
      if (c == 3'h2 && !wi)
         dec = {!p, b};
      else if (c == 3'h2)
         dec = {p || ($countones(b[7:2]) < 5), p ? ~b : b};
      else
         dec = {1'b1, (wi && p) ? ~b : b};
   endfunction
   // Stalls every other cycle unless held, so the buffer is always exercised
   always @(posedge mclk) begin
      wr_ready <= rst_n && !hold && !wr_ready;
      if (wr_valid && wr_ready)
         got.push_back({wr_byte_en, wr_data & {{8{wr_byte_en[1]}}, {8{wr_byte_en[0]}}}});
      if (wr_overrun)
         n_ovr <= n_ovr + 1;
      if (illegal_cmd)
         n_ill <= n_ill + 1;
      if (rd_underrun)
         n_und <= n_und + 1;
      if (rd_ready)
         n_rd <= n_rd + 1;
      // Read pattern index restarts at every take
      if (!rst_n || (cmd_valid && cmd_ready))
         rd_idx <= 4'h0;
      else if (rd_ready)
         rd_idx <= rd_idx + 4'h1;
   end
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      total_checks = total_checks + 1;
      if (g !== e) begin
         num_errors = num_errors + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic stop_test();
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmd(input [2:0] c, input [7:0] m3, input [7:0] m13);
      @(posedge mclk);
      mr3 <= m3;
      mode_register_thirteen <= m13;
      cmd_code <= c;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
   endtask
   task automatic t_write(input [2:0] c, input bit me, input bit wi, input bit stall);
      integer k, o0, i0;
      logic [8:0] lo, hi;
      got.delete();
      exp.delete();
      o0 = n_ovr;
      i0 = n_ill;
      for (k = 0; k < 16; k = k + 1) begin
         ctrl.tx_dq[k] = {8'hFF << k[2:0], 8'hFF >> k[2:0]};
         ctrl.tx_pin[k] = (c == 3'h1 && me && !wi) ? 2'b00 : {k[3], k[0]};
         lo = dec(c, wi, ctrl.tx_dq[k][7:0], ctrl.tx_pin[k][0]);
         hi = dec(c, wi, ctrl.tx_dq[k][15:8], ctrl.tx_pin[k][1]);
         if (c != 3'h5 && (me || c == 3'h1) && (lo[8] || hi[8]))
            exp.push_back({hi[8], lo[8], hi[7:0] & {8{hi[8]}}, lo[7:0] & {8{lo[8]}}});
      end
      hold <= stall;
      cmd(c, {wi, 7'h00}, {2'b00, !me, 5'h00});
      ctrl.drive = 1'b1;
      ctrl.burst();
      repeat (12) @(posedge mclk);
      if (stall) begin
         check(wr_in_ready, 1'b0);
         check(n_ovr - o0, 14);
         while (exp.size() > 2)
            void'(exp.pop_back());
         hold <= 1'b0;
         repeat (12) @(posedge mclk);
      end
      check(n_ill - i0, c == 3'h2 && !me);
      check(got.size(), exp.size());
      for (k = 0; k < exp.size(); k = k + 1)
         check(got[k], exp[k]);
   endtask
   task automatic t_read(input [2:0] c, input bit ri, input bit wi);
      integer k, n0, u0;
      logic [8:0] lo, hi;
      logic [15:0] d;
      n0 = n_rd;
      u0 = n_und;
      rd_valid <= (c != 3'h4);
      cmd(c, {wi, ri, 6'h00}, 8'h20);
      ctrl.drive = 1'b0;
      ctrl.burst();
      repeat (12) @(posedge mclk);
      check(n_rd - n0, (c == 3'h6) ? 0 : 16);
      check(n_und - u0, (c == 3'h4) ? 16 : 0);
      for (k = 0; k < 16; k = k + 1) begin
         d = (c == 3'h6) ? ctrl.tx_dq[k] : rd_pat(k);
         lo = (ri && c != 3'h6) ? enc(d[7:0]) : {1'b0, d[7:0]};
         hi = (ri && c != 3'h6) ? enc(d[15:8]) : {1'b0, d[15:8]};
         if (c == 3'h6)
            {hi[8], lo[8]} = ctrl.tx_pin[k];
         check({ctrl.rx_oe[k], ctrl.rx_pin[k], ctrl.rx_dq[k]}, {(ri || c == 3'h6) ? 2'b11 : 2'b00, hi[8], lo[8], hi[7:0], lo[7:0]});
      end
   endtask
   initial begin
      #50000;
      num_errors = num_errors + 1;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 3'h0;
      mr3 = 8'h00;
      mode_register_thirteen = 8'h20;
      hold = 1'b0;
      rd_valid = 1'b1;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
         t_write(3'h1, i[1], i[0], 1'b0);
      t_write(3'h2, 1'b1, 1'b0, 1'b0);
      t_write(3'h2, 1'b1, 1'b1, 1'b0);
      t_write(3'h2, 1'b0, 1'b1, 1'b0);
      t_write(3'h1, 1'b0, 1'b0, 1'b1);
      for (i = 0; i < 4; i = i + 1)
         t_read(i[1] ? 3'h4 : 3'h3, i[0], 1'b0);
      t_write(3'h5, 1'b0, 1'b1, 1'b0);
      t_read(3'h6, 1'b0, 1'b1);
      stop_test();
   end
endmodule // tb_byte_lane_mask_inversion
